// [cdr_regs.v]
// cdr_regs.v
// status and control register bank of a clock and data recovery receiver,
// reached as a slave on the two-wire serial host port (7-bit address)
// assumes SCL, SDA and the recovery core status lines are asynchronous to
// CLOCK; the SDA pad pulls low while SDA_OE is high
//
// Functional notes
// R1 - status bit 5 reads signal loss
// R2 - status bit 4 reads acquiring, 0 locked
// R3 - status bit 3 reads signal-loss action done
// R4 - status bit 2 sticky lock loss flag
// R5 - status bit 0 latches measurement done
// R6 - mode field: 000 data, 010 reference
// R7 - mode reg bit 2 clears sticky flag
// R8 - mode reg bit 1 starts rate measurement
// R9 - mode reg bit 0 clears measurement result
// R10 - reset bit written 1 then 0 resets
// R11 - kick bit 1 then 0 restarts acquisition
// R12 - bit 3 powers down signal-loss detector
// R13 - bit 2 inverts signal-loss pin polarity
// R14 - reference clock on when bit 2 zero
// R15 - bit 6 picks lock compare against data
// R16 - two-bit reference band selection
// R17 - ratio equals two to code minus one
// R18 - data times ratio equals divided reference
// R19 - edge field picks phase detector edges
// R20 - bandwidth scales by field over four
// R21 - reserved bits fixed, writes ignored
`timescale 1ns/1ps
`include "cdr_defines.vh"

module cdr_regs #(
  parameter [6:0] DEV_ADDR = 7'h40  // bus address, value arbitrary
) (
  // clock and reset
  input  wire        CLOCK,
  input  wire        RST_N,
  // two-wire host port
  input  wire        SCL_IN,
  input  wire        SDA_IN,
  output wire        SDA_OUT,
  output wire        SDA_OE,
  // recovery core status
  input  wire        SIGNAL_LOSS_IN,
  input  wire        LOCK_LOSS_IN,
  input  wire        SIGNAL_LOSS_DONE_IN,
  input  wire        RATE_DONE_IN,
  // recovery core strobes
  output wire        RATE_START,
  output wire        RATE_CLEAR,
  output wire        CORE_RESET,
  output wire        ACQUIRE_KICK,
  // recovery core settings
  output wire [2:0]  RECOVERY_MODE_SEL,
  output wire        LOCK_TO_REFERENCE,
  output wire        CDR_BYPASS,
  output wire        LOCK_LOSS_STATIC,
  output wire        SIGNAL_LOSS_POWERDOWN,
  output wire        SIGNAL_LOSS_PIN,
  output wire        REF_CLOCK_POWERDOWN,
  output wire        LOCK_COMPARE_DATA,
  output wire [1:0]  REF_BAND_SEL,
  output wire [3:0]  REF_DIVIDER,
  output wire [3:0]  RATE_RATIO_CODE,
  output wire [15:0] RATE_RATIO_HALVES,
  output wire        PD_RISE_EN,
  output wire        PD_FALL_EN,
  output wire [2:0]  LOOP_BW_SCALE
);

  // ----------------------------------------------------------------------
  // serial engine states
  // ----------------------------------------------------------------------
  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_ADDR = 4'h1;
  localparam [3:0] ST_AACK = 4'h2;
  localparam [3:0] ST_PTR  = 4'h3;
  localparam [3:0] ST_PACK = 4'h4;
  localparam [3:0] ST_WDAT = 4'h5;
  localparam [3:0] ST_WACK = 4'h6;
  localparam [3:0] ST_RDAT = 4'h7;
  localparam [3:0] ST_RACK = 4'h8;

  // ----------------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------------
  wire [5:0]  sync_q;
  reg         scl_d_reg;
  reg         sda_d_reg;
  reg         rdone_d_reg;
  reg  [3:0]  state_reg;
  reg  [3:0]  cnt_reg;
  reg  [7:0]  shift_reg;
  reg  [7:0]  tx_reg;
  reg  [7:0]  ptr_reg;
  reg         rw_reg;
  reg         nack_reg;
  reg         oe_reg;
  reg         wr_stb_reg;
  reg  [7:0]  wr_ptr_reg;
  reg  [7:0]  wr_dat_reg;
  reg  [7:0]  mode_reg;
  reg  [7:0]  rstacq_reg;
  reg  [7:0]  refpwr_reg;
  reg  [7:0]  reflck_reg;
  reg  [7:0]  loop_reg;
  reg         sticky_reg;
  reg         rdone_reg;
  reg         start_reg;
  reg         clear_reg;
  reg         core_rst_reg;
  reg         kick_reg;
  reg         pin_reg;
  reg         to_ref_reg;
  reg         cmp_data_reg;
  reg  [3:0]  ref_div_reg;
  reg  [15:0] halves_reg;
  reg         rise_en_reg;
  reg         fall_en_reg;
  reg  [7:0]  rd_data;
  wire [7:0]  status_byte;

  // ----------------------------------------------------------------------
  // input synchronisers and edge detection
  // ----------------------------------------------------------------------
  cdr_sync #(
    .WIDTH     (6),
    .RESET_VAL (6'h03)
  ) u_sync (
    .clock (CLOCK),
    .rst_n (RST_N),
    .din   ({RATE_DONE_IN, SIGNAL_LOSS_DONE_IN, LOCK_LOSS_IN,
             SIGNAL_LOSS_IN, SDA_IN, SCL_IN}),
    .dout  (sync_q)
  );

  wire scl_s     = sync_q[0];
  wire sda_s     = sync_q[1];
  wire sloss_s   = sync_q[2];
  wire lloss_s   = sync_q[3];
  wire sdone_s   = sync_q[4];
  wire rdone_s   = sync_q[5];
  wire scl_rise  = scl_s & ~scl_d_reg;
  wire scl_fall  = ~scl_s & scl_d_reg;
  wire bus_start = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
  wire bus_stop  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;
  wire byte_end  = scl_fall & (cnt_reg == `CDR_BYTE_BITS);

  // delayed copies for edge detection
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      scl_d_reg   <= 1'b1;
      sda_d_reg   <= 1'b1;
      rdone_d_reg <= 1'b0;
    end else begin
      scl_d_reg   <= scl_s;
      sda_d_reg   <= sda_s;
      rdone_d_reg <= rdone_s;
    end
  end

  // ----------------------------------------------------------------------
  // serial slave engine
  // ----------------------------------------------------------------------
  // bits are taken on SCL rise, SDA changes only after SCL fall
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      state_reg  <= ST_IDLE;
      cnt_reg    <= 4'h0;
      shift_reg  <= 8'h00;
      tx_reg     <= 8'h00;
      ptr_reg    <= 8'h00;
      rw_reg     <= 1'b0;
      nack_reg   <= 1'b0;
      oe_reg     <= 1'b0;
      wr_stb_reg <= 1'b0;
      wr_ptr_reg <= 8'h00;
      wr_dat_reg <= 8'h00;
    end else begin
      wr_stb_reg <= 1'b0;
      if (bus_start) begin
        state_reg <= ST_ADDR;
        cnt_reg   <= 4'h0;
        oe_reg    <= 1'b0;
      end else if (bus_stop) begin
        state_reg <= ST_IDLE;
        oe_reg    <= 1'b0;
      end else begin
        case (state_reg)
          ST_ADDR, ST_PTR, ST_WDAT: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_s};
              cnt_reg   <= cnt_reg + 4'h1;
            end else if (byte_end) begin
              cnt_reg <= 4'h0;
              if (state_reg == ST_ADDR) begin
                if (shift_reg[7:1] == DEV_ADDR) begin
                  oe_reg    <= 1'b1;
                  rw_reg    <= shift_reg[0];
                  state_reg <= ST_AACK;
                end else begin
                  state_reg <= ST_IDLE;  // not ours, stay off the bus
                end
              end else if (state_reg == ST_PTR) begin
                oe_reg    <= 1'b1;
                ptr_reg   <= shift_reg;
                state_reg <= ST_PACK;
              end else begin
                oe_reg     <= 1'b1;
                wr_stb_reg <= 1'b1;
                wr_ptr_reg <= ptr_reg;
                wr_dat_reg <= shift_reg;
                state_reg  <= ST_WACK;
              end
            end
          end
          ST_AACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                tx_reg    <= rd_data;
                oe_reg    <= ~rd_data[7];
                state_reg <= ST_RDAT;
              end else begin
                oe_reg    <= 1'b0;
                state_reg <= ST_PTR;
              end
            end
          end
          ST_PACK, ST_WACK: begin
            if (scl_fall) begin
              oe_reg    <= 1'b0;
              state_reg <= ST_WDAT;
              if (state_reg == ST_WACK) begin
                ptr_reg <= ptr_reg + 8'h01;
              end
            end
          end
          ST_RDAT: begin
            if (scl_rise) begin
              cnt_reg <= cnt_reg + 4'h1;
            end else if (byte_end) begin
              oe_reg    <= 1'b0;  // release for the host acknowledge
              cnt_reg   <= 4'h0;
              ptr_reg   <= ptr_reg + 8'h01;
              state_reg <= ST_RACK;
            end else if (scl_fall) begin
              tx_reg <= {tx_reg[6:0], 1'b0};
              oe_reg <= ~tx_reg[6];
            end
          end
          ST_RACK: begin
            if (scl_rise) begin
              nack_reg <= sda_s;
            end else if (scl_fall) begin
              if (nack_reg) begin
                state_reg <= ST_IDLE;
              end else begin
                tx_reg    <= rd_data;
                oe_reg    <= ~rd_data[7];
                state_reg <= ST_RDAT;
              end
            end
          end
          default: begin
            oe_reg <= 1'b0;
          end
        endcase
      end
    end
  end

  // ----------------------------------------------------------------------
  // write decode and sequence detection
  // ----------------------------------------------------------------------
  wire wr_mode   = wr_stb_reg & (wr_ptr_reg == `CDR_OFF_MODE);
  wire wr_rstacq = wr_stb_reg & (wr_ptr_reg == `CDR_OFF_RSTACQ);
  wire wr_refpwr = wr_stb_reg & (wr_ptr_reg == `CDR_OFF_REFPWR);
  wire wr_reflck = wr_stb_reg & (wr_ptr_reg == `CDR_OFF_REFLCK);
  wire wr_loop   = wr_stb_reg & (wr_ptr_reg == `CDR_OFF_LOOP);
  // a stored 1 overwritten by 0 marks the end of each two-write sequence
  wire soft_rst  = wr_rstacq & rstacq_reg[`CDR_RA_SWRST]
                   & ~wr_dat_reg[`CDR_RA_SWRST];  // R10
  wire kick_seq  = wr_rstacq & rstacq_reg[`CDR_RA_KICK]
                   & ~wr_dat_reg[`CDR_RA_KICK];  // R11
  wire [2:0] mode_f = mode_reg[`CDR_MD_HI:`CDR_MD_LO];
  wire [1:0] edge_f = loop_reg[`CDR_LP_EDGE_HI:`CDR_LP_EDGE_LO];
  wire [1:0] band_f = reflck_reg[`CDR_RL_BAND_HI:`CDR_RL_BAND_LO];
  wire [3:0] rat_f  = reflck_reg[`CDR_RL_RAT_HI:`CDR_RL_RAT_LO];
  wire sloss_live   = sloss_s & ~rstacq_reg[`CDR_RA_PDN];  // R12

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  // reserved bits are masked off on write and read back fixed
  always @(posedge CLOCK) begin
    if (!RST_N || soft_rst) begin
      mode_reg   <= `CDR_RST_MODE;
      rstacq_reg <= `CDR_RST_RSTACQ;
      refpwr_reg <= `CDR_RST_REFPWR;
      reflck_reg <= `CDR_RST_REFLCK;
      loop_reg   <= `CDR_RST_LOOP;
    end else begin
      if (wr_mode) begin
        mode_reg <= wr_dat_reg & `CDR_WM_MODE;  // R6 R21
      end
      if (wr_rstacq) begin
        rstacq_reg <= wr_dat_reg & `CDR_WM_RSTACQ;  // R21
      end
      if (wr_refpwr) begin
        refpwr_reg <= (wr_dat_reg & `CDR_WM_REFPWR) | `CDR_FIX_REFPWR;  // R14
      end
      if (wr_reflck) begin
        reflck_reg <= wr_dat_reg & `CDR_WM_REFLCK;
      end
      if (wr_loop) begin
        loop_reg <= wr_dat_reg & `CDR_WM_LOOP;
      end
    end
  end

  // ----------------------------------------------------------------------
  // sticky status flags
  // ----------------------------------------------------------------------
  // a set in the same cycle as a clear wins
  always @(posedge CLOCK) begin
    if (!RST_N || soft_rst) begin
      sticky_reg <= 1'b0;
      rdone_reg  <= 1'b0;
    end else begin
      if (lloss_s) begin
        sticky_reg <= 1'b1;  // R4
      end else if (wr_mode && wr_dat_reg[`CDR_MD_LLCLR]) begin
        sticky_reg <= 1'b0;  // R7
      end
      if (rdone_s && !rdone_d_reg) begin
        rdone_reg <= 1'b1;  // R5
      end else if (wr_mode && wr_dat_reg[`CDR_MD_RCLR]) begin
        rdone_reg <= 1'b0;  // R9
      end
    end
  end

  // ----------------------------------------------------------------------
  // strobes and decoded settings toward the core
  // ----------------------------------------------------------------------
  always @(posedge CLOCK) begin
    if (!RST_N) begin
      start_reg    <= 1'b0;
      clear_reg    <= 1'b0;
      core_rst_reg <= 1'b0;
      kick_reg     <= 1'b0;
      pin_reg      <= 1'b0;
      to_ref_reg   <= 1'b0;
      cmp_data_reg <= 1'b0;
      ref_div_reg  <= 4'h1;
      halves_reg   <= 16'h0001;
      rise_en_reg  <= 1'b1;
      fall_en_reg  <= 1'b1;
    end else begin
      start_reg    <= wr_mode & wr_dat_reg[`CDR_MD_RSTART];  // R8
      clear_reg    <= wr_mode & wr_dat_reg[`CDR_MD_RCLR];  // R9
      core_rst_reg <= soft_rst;  // R10
      kick_reg     <= kick_seq;  // R11
      pin_reg      <= sloss_live ^ rstacq_reg[`CDR_RA_POL];  // R13
      to_ref_reg   <= (mode_f == `RECOVERY_MODE_SEL_REF);  // R6
      cmp_data_reg <= (mode_f == `RECOVERY_MODE_SEL_REF)
                      & reflck_reg[`CDR_RL_CMP];  // R15
      ref_div_reg  <= 4'h1 << band_f;  // R16 R18
      halves_reg   <= 16'h0001 << rat_f;  // R17 R18
      rise_en_reg  <= (edge_f != `CDR_EDGE_FALL);  // R19
      fall_en_reg  <= (edge_f != `CDR_EDGE_RISE);  // R19
    end
  end

  // ----------------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------------
  assign status_byte = {2'b00,
                        sloss_live,  // R1
                        lloss_s,  // R2
                        sdone_s,  // R3
                        sticky_reg,
                        1'b0,
                        rdone_reg};

  // unmapped offsets read zero
  always @* begin
    case (ptr_reg)
      `CDR_OFF_STATUS: rd_data = status_byte;
      `CDR_OFF_MODE:   rd_data = mode_reg;
      `CDR_OFF_RSTACQ: rd_data = rstacq_reg;
      `CDR_OFF_REFPWR: rd_data = refpwr_reg;
      `CDR_OFF_REFLCK: rd_data = reflck_reg;
      `CDR_OFF_LOOP:   rd_data = loop_reg;
      default:         rd_data = 8'h00;
    endcase
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign SDA_OUT               = 1'b0;  // open drain, only ever pulls low
  assign SDA_OE                = oe_reg;
  assign RATE_START            = start_reg;
  assign RATE_CLEAR            = clear_reg;
  assign CORE_RESET            = core_rst_reg;
  assign ACQUIRE_KICK          = kick_reg;
  assign RECOVERY_MODE_SEL     = mode_f;
  assign LOCK_TO_REFERENCE     = to_ref_reg;
  assign CDR_BYPASS            = rstacq_reg[`CDR_RA_BYPASS];
  assign LOCK_LOSS_STATIC      = rstacq_reg[`CDR_RA_STATIC];
  assign SIGNAL_LOSS_POWERDOWN = rstacq_reg[`CDR_RA_PDN];
  assign SIGNAL_LOSS_PIN       = pin_reg;
  assign REF_CLOCK_POWERDOWN   = refpwr_reg[`CDR_RP_PDN];
  assign LOCK_COMPARE_DATA     = cmp_data_reg;
  assign REF_BAND_SEL          = band_f;
  assign REF_DIVIDER           = ref_div_reg;
  assign RATE_RATIO_CODE       = rat_f;
  assign RATE_RATIO_HALVES     = halves_reg;
  assign PD_RISE_EN            = rise_en_reg;
  assign PD_FALL_EN            = fall_en_reg;
  assign LOOP_BW_SCALE         = loop_reg[`CDR_LP_BW_HI:`CDR_LP_BW_LO];  // R20

endmodule

// [cdr_defines.vh]
// cdr_defines.vh
// offsets, field positions, write masks and reset values of the register bank
// assumes it is included by bare name from the register bank sources
`ifndef CDR_DEFINES_VH
`define CDR_DEFINES_VH
// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define CDR_OFF_STATUS 8'h06
`define CDR_OFF_MODE   8'h08
`define CDR_OFF_RSTACQ 8'h09
`define CDR_OFF_REFPWR 8'h0A
`define CDR_OFF_REFLCK 8'h0F
`define CDR_OFF_LOOP   8'h10
// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define CDR_RST_MODE   8'h00
`define CDR_RST_RSTACQ 8'h00
`define CDR_RST_REFPWR 8'h05
`define CDR_RST_REFLCK 8'h00
`define CDR_RST_LOOP   8'h1C
// ----------------------------------------------------------------------
// writable bits and fixed bits
// ----------------------------------------------------------------------
`define CDR_WM_MODE    8'h70
`define CDR_WM_RSTACQ  8'hFC
`define CDR_WM_REFPWR  8'h04
`define CDR_WM_REFLCK  8'h7F
`define CDR_WM_LOOP    8'h1F
`define CDR_FIX_REFPWR 8'h01
// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define CDR_ST_SLOSS   5
`define CDR_ST_LLOSS   4
`define CDR_ST_SDONE   3
`define CDR_ST_STICKY  2
`define CDR_ST_RDONE   0
`define CDR_MD_HI      6
`define CDR_MD_LO      4
`define CDR_MD_LLCLR   2
`define CDR_MD_RSTART  1
`define CDR_MD_RCLR    0
`define CDR_RA_SWRST   7
`define CDR_RA_KICK    6
`define CDR_RA_BYPASS  5
`define CDR_RA_STATIC  4
`define CDR_RA_PDN     3
`define CDR_RA_POL     2
`define CDR_RP_PDN     2
`define CDR_RL_CMP     6
`define CDR_RL_BAND_HI 5
`define CDR_RL_BAND_LO 4
`define CDR_RL_RAT_HI  3
`define CDR_RL_RAT_LO  0
`define CDR_LP_EDGE_HI 4
`define CDR_LP_EDGE_LO 3
`define CDR_LP_BW_HI   2
`define CDR_LP_BW_LO   0
// ----------------------------------------------------------------------
// codes and counts
// ----------------------------------------------------------------------
`define RECOVERY_MODE_SEL_REF   3'b010
`define CDR_EDGE_RISE  2'b01
`define CDR_EDGE_FALL  2'b10
`define CDR_BYTE_BITS  4'h8
`endif

// [cdr_sync.v]
// cdr_sync.v
// two flip-flop synchroniser for a group of asynchronous levels
// assumes inputs are slow levels; the reset value sets the idle level
`timescale 1ns/1ps

module cdr_sync #(
  parameter             WIDTH     = 6,
  parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b0}}
) (
  // clock and reset
  input  wire             clock,
  input  wire             rst_n,
  // levels
  input  wire [WIDTH-1:0] din,
  output wire [WIDTH-1:0] dout
);

  // ----------------------------------------------------------------------
  // one pair of flops per bit
  // ----------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // the first flop feeds only the second
      always @(posedge clock) begin
        if (!rst_n) begin
          meta_reg <= RESET_VAL[i];
          sync_reg <= RESET_VAL[i];
        end else begin
          meta_reg <= din[i];
          sync_reg <= meta_reg;
        end
      end
      assign dout[i] = sync_reg;
    end
  endgenerate

endmodule

// [cdr_regs_properties.sv]
// cdr_regs_properties.sv
// checker on the ports of the register bank: decodes and strobes
// assumes it is bound to cdr_regs and sees only its ports
`timescale 1ns/1ps
module cdr_props (
  // clock and reset
  input wire        CLOCK,
  input wire        RST_N,
  // settings
  input wire [2:0]  RECOVERY_MODE_SEL,
  input wire        LOCK_TO_REFERENCE,
  input wire        LOCK_COMPARE_DATA,
  input wire [1:0]  REF_BAND_SEL,
  input wire [3:0]  REF_DIVIDER,
  input wire [3:0]  RATE_RATIO_CODE,
  input wire [15:0] RATE_RATIO_HALVES,
  input wire        PD_RISE_EN,
  input wire        PD_FALL_EN,
  input wire        REF_CLOCK_POWERDOWN,
  input wire [2:0]  LOOP_BW_SCALE,
  // strobes
  input wire        RATE_START,
  input wire        RATE_CLEAR,
  input wire        CORE_RESET,
  input wire        ACQUIRE_KICK
);
  default clocking cb @(posedge CLOCK);
  endclocking
  default disable iff (!RST_N);
  // decodes follow their field once it has settled
  property p_ltr;
    $stable(RECOVERY_MODE_SEL) |-> LOCK_TO_REFERENCE == (RECOVERY_MODE_SEL == 3'b010);
  endproperty
  a_ltr: assert property (p_ltr) else $error("mode decode wrong");
  property p_cmp;
    LOCK_COMPARE_DATA |-> LOCK_TO_REFERENCE;
  endproperty
  a_cmp: assert property (p_cmp) else $error("data compare outside ref mode");
  property p_div;
    $stable(REF_BAND_SEL) |-> REF_DIVIDER == (4'h1 << REF_BAND_SEL);
  endproperty
  a_div: assert property (p_div) else $error("band divider wrong");
  property p_ratio;
    $stable(RATE_RATIO_CODE) |-> RATE_RATIO_HALVES == (16'h0001 << RATE_RATIO_CODE);
  endproperty
  a_ratio: assert property (p_ratio) else $error("ratio wrong");
  property p_edge;
    PD_RISE_EN || PD_FALL_EN;
  endproperty
  a_edge: assert property (p_edge) else $error("no edge enabled");
  // strobes last one cycle
  property p_start;
    RATE_START |=> !RATE_START;
  endproperty
  a_start: assert property (p_start) else $error("start too long");
  property p_clear;
    RATE_CLEAR |=> !RATE_CLEAR;
  endproperty
  a_clear: assert property (p_clear) else $error("clear too long");
  property p_kick;
    $rose(ACQUIRE_KICK) |=> !ACQUIRE_KICK [*2];
  endproperty
  a_kick: assert property (p_kick) else $error("kick too long");
  // stored settings are back at reset values when the core reset fires
  property p_rst;
    CORE_RESET |-> REF_CLOCK_POWERDOWN && LOOP_BW_SCALE == 3'h4 && RECOVERY_MODE_SEL == 3'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("reset left settings");
endmodule
bind cdr_regs cdr_props i_props (.*);

// [cdr_host.sv]
// cdr_host.sv
// two-wire host model: byte writes and single-byte reads
// assumes the bench builds the pulled-up wire from both open drains
`timescale 1ns/1ps
module cdr_host #(
  parameter [6:0] DEV = 7'h40 // bus address, value arbitrary
) (
  // clock
  input  wire clk,
  // two-wire pins
  output reg  scl,
  output reg  sdo,
  input  wire sda
);
  integer nack;
  initial begin
    scl = 1'b1;
    sdo = 1'b1;
    nack = 0;
  end
  // eight clocks keep each scl phase above the minimum
  task half;
    repeat (8) @(posedge clk);
  endtask
  // one bit; sda moves only while scl is low
  task clk_bit(input b, output r);
    begin
      @(posedge clk) sdo <= b;
      half;
      scl <= 1'b1;
      half;
      r = sda;
      scl <= 1'b0;
    end
  endtask
  // byte out, then count a missing acknowledge
  task send(input [7:0] d);
    integer i;
    reg     r;
    begin
      for (i = 7; i >= 0; i = i - 1)
        clk_bit(d[i], r);
      clk_bit(1'b1, r);
      if (r !== 1'b0)
        nack = nack + 1;
    end
  endtask
  // start and repeated start
  task start;
    begin
      @(posedge clk) sdo <= 1'b1;
      half;
      scl <= 1'b1;
      half;
      sdo <= 1'b0;
      half;
      scl <= 1'b0;
    end
  endtask
  task stop;
    begin
      @(posedge clk) sdo <= 1'b0;
      half;
      scl <= 1'b1;
      half;
      sdo <= 1'b1;
      half;
    end
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      start;
      send({DEV, 1'b0});
      send(a);
      send(d);
      stop;
    end
  endtask
  task rd(input [7:0] a, output [7:0] d);
    integer i;
    reg     r;
    begin
      start;
      send({DEV, 1'b0});
      send(a);
      start;
      send({DEV, 1'b1});
      for (i = 7; i >= 0; i = i - 1) begin
        clk_bit(1'b1, r);
        d[i] = r;
      end
      clk_bit(1'b1, r); // refuse further bytes
      stop;
    end
  endtask
endmodule

// [cdr_status_control_regs_bench.sv]
// cdr_status_control_regs_bench.sv
// self-checking bench of the register bank over the two-wire port
// assumes cdr_host as the bus partner and the bound checker
`timescale 1ns/1ps
module cdr_status_control_regs_bench;
  reg         clock;
  reg         rst_n;
  reg         sig_loss;
  reg         lock_loss;
  reg         loss_done;
  reg         rate_done;
  wire        scl;
  wire        sdo;
  wire        sda_oe;
  wire        sda = sdo & ~sda_oe; // pull-up, either side pulls low
  wire        st, cl, rs, kk, lock_to_reference, pin, pdn, lcd, rise, fall, byp, stc, spd;
  wire [3:0]  div;
  wire [15:0] halves;
  wire [2:0]  bw;
  integer     n_fail, compares, n_st, n_cl, n_rs, n_kk, i, c;
  reg  [7:0]  v;
  cdr_regs i_dut (
    .CLOCK(clock), .RST_N(rst_n), .SCL_IN(scl), .SDA_IN(sda),
    .SDA_OUT(), .SDA_OE(sda_oe), .SIGNAL_LOSS_IN(sig_loss),
    .LOCK_LOSS_IN(lock_loss), .SIGNAL_LOSS_DONE_IN(loss_done),
    .RATE_DONE_IN(rate_done), .RATE_START(st), .RATE_CLEAR(cl),
    .CORE_RESET(rs), .ACQUIRE_KICK(kk), .RECOVERY_MODE_SEL(),
    .LOCK_TO_REFERENCE(lock_to_reference), .CDR_BYPASS(byp), .LOCK_LOSS_STATIC(stc),
    .SIGNAL_LOSS_POWERDOWN(spd), .SIGNAL_LOSS_PIN(pin),
    .REF_CLOCK_POWERDOWN(pdn), .LOCK_COMPARE_DATA(lcd), .REF_BAND_SEL(),
    .REF_DIVIDER(div), .RATE_RATIO_CODE(), .RATE_RATIO_HALVES(halves),
    .PD_RISE_EN(rise), .PD_FALL_EN(fall), .LOOP_BW_SCALE(bw));
  cdr_host i_host (.clk(clock), .scl(scl), .sdo(sdo), .sda(sda));
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // count strobe cycles
  always @(posedge clock) begin
    if (st === 1'b1) n_st <= n_st + 1;
    if (cl === 1'b1) n_cl <= n_cl + 1;
    if (rs === 1'b1) n_rs <= n_rs + 1;
    if (kk === 1'b1) n_kk <= n_kk + 1;
  end
  task chk(input [15:0] got, input [15:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task rchk(input [7:0] a, input [7:0] e);
    reg [7:0] d;
    begin
      i_host.rd(a, d);
      chk(16'(d), 16'(e));
    end
  endtask
  task final_report;
    begin
      $display("compares=%0d n_fail=%0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    {n_fail, compares, n_st, n_cl, n_rs, n_kk} = 0;
    {sig_loss, lock_loss, loss_done, rate_done} = 4'h0;
    rst_n = 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
    // reset values
    rchk(8'h08, 8'h00);
    rchk(8'h09, 8'h00);
    rchk(8'h0A, 8'h05);
    rchk(8'h0F, 8'h00);
    rchk(8'h10, 8'h1C);
    $display("test reset done");
    // mode codes 0 to 3
    for (i = 0; i < 4; i = i + 1) begin
      i_host.wr(8'h08, 8'(i << 4));
      chk(16'(lock_to_reference), 16'(i == 2));
    end
    // bands and ratios in reference mode
    i_host.wr(8'h08, 8'h20);
    for (i = 0; i < 4; i = i + 1) begin
      c = (i == 3) ? 10 : i;
      v = 8'h40 | 8'(i << 4) | 8'(c);
      i_host.wr(8'h0F, v);
      rchk(8'h0F, v);
      chk(16'(div), 16'(1 << i));
      chk(halves, 16'(1 << c));
      chk(16'(lcd), 16'h0001);
    end
    i_host.wr(8'h08, 8'h00);
    chk(16'(lcd), 16'h0000);
    $display("test modes done");
    // edge select and bandwidth
    for (i = 0; i < 4; i = i + 1) begin
      v = 8'(i << 3) | 8'(i + 3);
      i_host.wr(8'h10, v);
      rchk(8'h10, v);
      chk(16'({rise, fall}), 16'(i == 1 ? 2 : i == 2 ? 1 : 3));
      chk(16'(bw), 16'(i + 3));
    end
    $display("test loop done");
    // status flags, sticky and measurement clears
    sig_loss <= 1'b1;
    lock_loss <= 1'b1;
    loss_done <= 1'b1;
    rate_done <= 1'b1;
    rchk(8'h06, 8'h3D);
    chk(16'(pin), 16'h0001);
    lock_loss <= 1'b0;
    loss_done <= 1'b0;
    rchk(8'h06, 8'h25);
    i_host.wr(8'h08, 8'h02);
    chk(16'(n_st), 16'h0001);
    rchk(8'h08, 8'h00);
    i_host.wr(8'h08, 8'h04);
    rchk(8'h06, 8'h21);
    i_host.wr(8'h08, 8'h01);
    rchk(8'h06, 8'h20);
    chk(16'(n_cl), 16'h0001);
    i_host.wr(8'h09, 8'h04);
    chk(16'(pin), 16'h0000);
    i_host.wr(8'h09, 8'h3C);
    rchk(8'h06, 8'h00);
    chk(16'(pin), 16'h0001);
    chk(16'({byp, stc, spd}), 16'h0007);
    rchk(8'h09, 8'h3C);
    $display("test status done");
    // reference clock, acquisition kick, software reset
    i_host.wr(8'h0A, 8'h01);
    chk(16'(pdn), 16'h0000);
    rchk(8'h0A, 8'h01);
    i_host.wr(8'h09, 8'h40);
    i_host.wr(8'h09, 8'h00);
    chk(16'(n_kk), 16'h0001);
    i_host.wr(8'h09, 8'h80);
    chk(16'(n_rs), 16'h0000);
    i_host.wr(8'h09, 8'h00);
    chk(16'(n_rs), 16'h0001);
    rchk(8'h10, 8'h1C);
    chk(16'(pdn), 16'h0001);
    chk(16'(i_host.nack), 16'h0000);
    $display("test reset_seq done");
    final_report;
  end
endmodule
